// ### hdl/lin_fail_wake_status_pkg.sv
// types for the lin failure / wake status bank
// assumes: nothing beyond the register header
package lin_fail_wake_status_pkg;

    typedef enum logic [1:0] {
        FAULT_NONE        = 2'b00,
        FAULT_THERMAL     = 2'b01,
        FAULT_TX_DOMINANT = 2'b10,
        FAULT_BUS_DOMINANT = 2'b11
    } lin_fault_code_e;

    // per transceiver events and levels, same clock domain
    typedef struct packed {
        logic thermal_shutdown;
        logic transmit_dominant_timeout;
        logic bus_dominant_timeout;
        logic bus_recessive;
        logic wake_capable_or_off;
        logic supply_above_threshold;
    } lin_event_s;

    // wake events, one-cycle pulses
    typedef struct packed {
        logic       regulator_mode_change;
        logic       can_bus_wake;
        logic       timer_wake;
        logic       wake_pin_wake;
        logic [3:0] lin_wake;
    } wake_event_s;

    typedef struct packed {
        logic            valid;
        logic [6:0]      addr;
    } read_req_s;

    typedef struct packed {
        logic            ack;
        logic [7:0]      data;
    } read_rsp_s;

    typedef struct packed {
        logic [2:0][2:0]        txd_sync;
        logic [2:0]             txd_level;
        logic [2:0]             wake_sync;
        logic                   wake_level;
        logic [2:0]             test_sync;
        logic                   test_level;
        logic [2:0]             txd_dom_active;
        logic [2:0]             bus_dom_active;
        logic [2:0]             undervoltage_active;
        lin_fault_code_e [2:0]  fault_code;
        logic [7:0]             wake_a;
        logic [3:0]             wake_b;
        logic                   config_mirror;
        logic [2:0][15:0]       enable_count;
        logic [2:0]             tx_enable;
        logic                   thermal_first;
        read_rsp_s              rsp;
    } bank_state_s;

endpackage

// ### hdl/lin_fail_wake_status_regs.sv
// status bank: lin 2..4 failure codes, wake sources, live pin levels
// assumes: serial front end on ref_clk issues one-cycle read requests;
// transceiver events arrive on ref_clk, txd/test/wake pins are asynchronous
`timescale 1ns/1ps
`include "lin_fail_wake_status_regs.svh"

// Functional notes
// R1: fault register 0x45, lin4 6:5, lin3 4:3, lin2 2:1
// R2: codes none, thermal, txd timeout, bus timeout
// R3: reserved bits read zero, level bit6 one
// R4: power-on/soft reset clears fault, wake registers
// R5: txd timeout ends: txd high, wake/off
// R6: bus timeout ends: recessive, wake/off
// R7: undervoltage ends when supply above threshold
// R8: transmit re-enabled after txd high enable time
// R9: regulator mode change sets wake_a bit 7
// R10: wake_a 0x46: can 5, timer 4, pin 0
// R11: restart keeps wake_a bits 7,5,4,0 only
// R12: wake_b holds lin1..4 wakes in bits 0..3
// R13: restart keeps wake_b lin flags, upper zero
// R14: level register 0x48, bit0 wake input
// R15: level bit7 shows test pin, development mode
// R16: level bit5 mirrors fail output config bit
// R17: level register reset patterns x100/x1x0
// R18: read-clear flags clear on read unless present
module lin_fail_wake_status_regs #(
    parameter int unsigned TX_ENABLE_CYCLES = `TX_ENABLE_CYCLES
) (
    // clock, reset, enable
    input  wire logic                                         ref_clk,
    input  wire logic                                         reset,
    input  wire logic                                         clk_en,
    // device-level reset events
    input  wire logic                                         soft_reset,
    input  wire logic                                         restart,
    // asynchronous pins
    input  wire logic [2:0]                                   lin_transmit_input,
    input  wire logic                                         test_pin,
    input  wire logic                                         wake_input_pin,
    // same-clock sources
    input  wire logic                                         fail_output_config_bit,
    input  lin_fail_wake_status_pkg::lin_event_s  [2:0]       lin_event,
    input  lin_fail_wake_status_pkg::wake_event_s             wake_event,
    // register read port
    input  lin_fail_wake_status_pkg::read_req_s               read_req,
    output lin_fail_wake_status_pkg::read_rsp_s               read_rsp,
    // transceiver control
    output logic [2:0]                                        tx_enable,
    output logic                                              thermal_shutdown_first
);
    import lin_fail_wake_status_pkg::*;

    // the enable counter is 16 bits wide and must count at least once
    if (TX_ENABLE_CYCLES < 1 || TX_ENABLE_CYCLES > 65535) begin : tx_enable_range_check
        $error("TX_ENABLE_CYCLES must lie in 1..65535");
    end

    localparam logic [15:0] ENABLE_LAST = 16'(TX_ENABLE_CYCLES - 1);

    bank_state_s state_reg;
    bank_state_s state_next;

    function automatic lin_fault_code_e current_fault(input logic tsd, input logic bus_dom, input logic txd_dom);
        if (tsd) begin
            current_fault = FAULT_THERMAL;
        end else if (bus_dom) begin
            current_fault = FAULT_BUS_DOMINANT;
        end else if (txd_dom) begin
            current_fault = FAULT_TX_DOMINANT;
        end else begin
            current_fault = FAULT_NONE;
        end
    endfunction

    // filtered level moves only once the two later flops agree
    function automatic logic filter_level(input logic [2:0] chain, input logic held);
        filter_level = (chain[1] == chain[2]) ? chain[2] : held;
    endfunction

    function automatic logic [7:0] fault_byte(input lin_fault_code_e [2:0] code);
        fault_byte = 8'h00;
        fault_byte[`LIN_TWO_FAULT_LSB +: 2]   = code[0];
        fault_byte[`LIN_THREE_FAULT_LSB +: 2] = code[1];
        fault_byte[`LIN_FOUR_FAULT_LSB +: 2]  = code[2];
    endfunction

    always_comb begin
        logic            rd_fault;
        logic            rd_wake_a;
        logic            rd_wake_b;
        logic            txd_end;
        logic            bus_end;
        logic            any_fail;
        lin_fault_code_e cur;
        logic [7:0]      level_byte;
        rd_fault   = 1'b0;
        rd_wake_a  = 1'b0;
        rd_wake_b  = 1'b0;
        txd_end    = 1'b0;
        bus_end    = 1'b0;
        any_fail   = 1'b0;
        cur        = FAULT_NONE;
        level_byte = 8'h00;
        state_next = state_reg;

        // pin synchronisers; first flop feeds only the second
        for (int i = 0; i < 3; i++) begin
            state_next.txd_sync[i] = {state_reg.txd_sync[i][1:0], lin_transmit_input[i]};
            state_next.txd_level[i] = filter_level(state_reg.txd_sync[i], state_reg.txd_level[i]);
        end
        state_next.wake_sync  = {state_reg.wake_sync[1:0], wake_input_pin};
        state_next.wake_level = filter_level(state_reg.wake_sync, state_reg.wake_level);
        state_next.test_sync  = {state_reg.test_sync[1:0], test_pin};
        state_next.test_level = filter_level(state_reg.test_sync, state_reg.test_level);

        if (read_req.valid) begin
            rd_fault  = (read_req.addr == `LIN_FAULT_STATUS_B_ADDR);
            rd_wake_a = (read_req.addr == `WAKE_SOURCE_STATUS_A_ADDR);
            rd_wake_b = (read_req.addr == `WAKE_SOURCE_STATUS_B_ADDR);
        end

        // read answer reflects the value before this cycle's clear
        level_byte[`TEST_LEVEL_BIT]         = state_reg.test_level;        // [R15]
        level_byte[`LEVEL_RESERVED_ONE_BIT] = 1'b1;                        // [R3] [R17]
        level_byte[`FAIL_CONFIG_MIRROR_BIT] = state_reg.config_mirror;     // [R16]
        level_byte[`WAKE_INPUT_LEVEL_BIT]   = state_reg.wake_level;        // [R14]
        state_next.rsp.ack  = read_req.valid;
        state_next.rsp.data = 8'h00;
        if (read_req.valid) begin
            unique case (read_req.addr)
                `LIN_FAULT_STATUS_B_ADDR:   state_next.rsp.data = fault_byte(state_reg.fault_code); // [R1]
                `WAKE_SOURCE_STATUS_A_ADDR: state_next.rsp.data = state_reg.wake_a & `WAKE_A_RESTART_KEEP; // [R10] [R3]
                `WAKE_SOURCE_STATUS_B_ADDR: state_next.rsp.data = {4'h0, state_reg.wake_b};  // [R12] [R3]
                `PIN_LEVEL_STATUS_ADDR:     state_next.rsp.data = level_byte;
                default:                    state_next.rsp.data = 8'h00;
            endcase
        end

        state_next.thermal_first = 1'b0;
        for (int i = 0; i < 3; i++) begin
            // condition tracking; a new detection wins over its end
            txd_end = state_reg.txd_level[i] | lin_event[i].wake_capable_or_off;             // [R5]
            bus_end = lin_event[i].bus_recessive | lin_event[i].wake_capable_or_off;         // [R6]
            state_next.txd_dom_active[i] = lin_event[i].transmit_dominant_timeout
                                         | (state_reg.txd_dom_active[i] & ~txd_end);
            state_next.bus_dom_active[i] = lin_event[i].bus_dominant_timeout
                                         | (state_reg.bus_dom_active[i] & ~bus_end);
            // no new undervoltage report starts while the transceiver is wake capable or off; an active one is kept
            state_next.undervoltage_active[i] = ~lin_event[i].supply_above_threshold          // [R7]
                & (state_reg.undervoltage_active[i] | ~lin_event[i].wake_capable_or_off);

            cur = current_fault(lin_event[i].thermal_shutdown,
                                state_next.bus_dom_active[i], state_next.txd_dom_active[i]);   // [R2]
            if (cur == FAULT_THERMAL) begin
                state_next.thermal_first = 1'b1;                                             // [R2]
            end
            if (cur != FAULT_NONE || rd_fault) begin
                state_next.fault_code[i] = cur;                                              // [R18]
            end

            // transmitter held off until txd stays high for the enable time
            any_fail = lin_event[i].thermal_shutdown | state_next.txd_dom_active[i]
                     | state_next.bus_dom_active[i] | state_next.undervoltage_active[i];
            if (any_fail || !state_reg.txd_level[i]) begin
                state_next.enable_count[i] = 16'h0000;                                        // [R8]
                if (any_fail) begin
                    state_next.tx_enable[i] = 1'b0;                                          // [R8]
                end
            end else if (!state_reg.tx_enable[i]) begin
                if (state_reg.enable_count[i] >= ENABLE_LAST) begin
                    state_next.tx_enable[i] = 1'b1;                                          // [R8]
                end else begin
                    state_next.enable_count[i] = state_reg.enable_count[i] + 16'h0001;
                end
            end
        end

        // sticky wake flags; set wins over read clear
        if (rd_wake_a) begin
            state_next.wake_a = 8'h00;                                                       // [R18]
        end
        if (rd_wake_b) begin
            state_next.wake_b = 4'h0;                                                        // [R18]
        end
        if (wake_event.regulator_mode_change) begin
            state_next.wake_a[`REGULATOR_MODE_CHANGE_BIT] = 1'b1;                            // [R9]
        end
        if (wake_event.can_bus_wake) begin
            state_next.wake_a[`CAN_BUS_WAKE_BIT] = 1'b1;                                     // [R10]
        end
        if (wake_event.timer_wake) begin
            state_next.wake_a[`TIMER_WAKE_BIT] = 1'b1;                                       // [R10]
        end
        if (wake_event.wake_pin_wake) begin
            state_next.wake_a[`WAKE_PIN_WAKE_BIT] = 1'b1;                                    // [R10]
        end
        state_next.wake_b = state_next.wake_b | wake_event.lin_wake;                         // [R12]

        state_next.config_mirror = fail_output_config_bit;                                   // [R16]

        // restart keeps the listed flags and forces the rest low
        if (restart) begin
            state_next.wake_a = state_next.wake_a & `WAKE_A_RESTART_KEEP;                    // [R11]
            state_next.wake_b = state_next.wake_b & 4'(`WAKE_B_RESTART_KEEP);                // [R13]
        end
        // soft reset clears fault codes, wake flags and mirror as power-on does; condition tracking and tx_enable are kept
        if (soft_reset) begin
            for (int i = 0; i < 3; i++) begin
                state_next.fault_code[i] = FAULT_NONE;                                       // [R4]
            end
            state_next.wake_a        = `STATUS_RESET_VALUE;                                  // [R4]
            state_next.wake_b        = 4'h0;                                                 // [R4]
            state_next.config_mirror = 1'b0;                                                 // [R17]
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_reg           <= '0;                                                       // [R4] [R17]
            state_reg.tx_enable <= 3'h7;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

    assign read_rsp               = state_reg.rsp;
    assign tx_enable              = state_reg.tx_enable;
    assign thermal_shutdown_first = state_reg.thermal_first;

endmodule

// ### hdl/lin_fail_wake_status_regs.svh
// register map constants for the lin failure / wake status bank
// assumes: included by the bank only
`ifndef LIN_FAIL_WAKE_STATUS_REGS_SVH
`define LIN_FAIL_WAKE_STATUS_REGS_SVH

`define LIN_FAULT_STATUS_B_ADDR    7'h45
`define WAKE_SOURCE_STATUS_A_ADDR  7'h46
`define WAKE_SOURCE_STATUS_B_ADDR  7'h47
`define PIN_LEVEL_STATUS_ADDR      7'h48

`define LIN_FOUR_FAULT_LSB         5
`define LIN_THREE_FAULT_LSB        3
`define LIN_TWO_FAULT_LSB          1

`define REGULATOR_MODE_CHANGE_BIT  7
`define CAN_BUS_WAKE_BIT           5
`define TIMER_WAKE_BIT             4
`define WAKE_PIN_WAKE_BIT          0
`define WAKE_A_RESTART_KEEP        8'hB1
`define WAKE_B_RESTART_KEEP        8'h0F

`define TEST_LEVEL_BIT             7
`define LEVEL_RESERVED_ONE_BIT     6
`define FAIL_CONFIG_MIRROR_BIT     5
`define WAKE_INPUT_LEVEL_BIT       0

`define STATUS_RESET_VALUE         8'h00

// transmitter enable time, ns, and its cycle count at 40 MHz (rounded up)
`define TX_ENABLE_TIME_NS          10000
`define REF_CLK_PERIOD_NS          25
`define TX_ENABLE_CYCLES           ((`TX_ENABLE_TIME_NS + `REF_CLK_PERIOD_NS - 1) / `REF_CLK_PERIOD_NS)

`endif

// ### tb/status_bank_assertions.sv
// checker for the lin failure / wake status bank ports
// assumes: bound to the bank, one ref_clk domain, clk_en low only while no read or event is pending
`timescale 1ns/1ps
module status_bank_checker #(
    parameter int unsigned TX_ENABLE_CYCLES = 4
) (
    input wire logic                                    ref_clk,
    input wire logic                                    reset,
    input wire logic                                    soft_reset,
    input wire logic [2:0]                              lin_transmit_input,
    input lin_fail_wake_status_pkg::lin_event_s [2:0]   lin_event,
    input lin_fail_wake_status_pkg::wake_event_s        wake_event,
    input lin_fail_wake_status_pkg::read_req_s          read_req,
    input lin_fail_wake_status_pkg::read_rsp_s          read_rsp,
    input wire logic [2:0]                              tx_enable,
    input wire logic                                    thermal_shutdown_first
);
    import lin_fail_wake_status_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    logic [15:0] ok_cnt;
    logic        lane_bad;
    logic        any_thermal;
    // raw pin count is a safe upper bound on the filtered count
    assign lane_bad = lin_event[0].thermal_shutdown | lin_event[0].transmit_dominant_timeout
        | lin_event[0].bus_dominant_timeout | !lin_transmit_input[0] | !lin_event[0].supply_above_threshold
        | !(lin_event[0].bus_recessive | lin_event[0].wake_capable_or_off);
    assign any_thermal = lin_event[0].thermal_shutdown | lin_event[1].thermal_shutdown
        | lin_event[2].thermal_shutdown;
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            ok_cnt <= '0;
        end else if (lane_bad) begin
            ok_cnt <= '0;
        end else if (ok_cnt != 16'hFFFF) begin
            ok_cnt <= ok_cnt + 16'h1;
        end
    end
    sequence rd_at(logic [6:0] a);
        read_req.valid && read_req.addr == a;
    endsequence
    sequence ev_then_read(logic ev, logic [6:0] a);
        ev && !soft_reset ##1 !read_req.valid && !soft_reset
            ##1 read_req.valid && read_req.addr == a && !soft_reset;
    endsequence
    property flag_seen(logic ev, logic [6:0] a, int b);
        ev_then_read(ev, a) |=> read_rsp.data[b];
    endproperty
    chk_ack_next:
        assert property (read_req.valid |=> read_rsp.ack) else $error("read not answered");
    chk_ack_cause:
        assert property (read_rsp.ack |-> $past(read_req.valid)) else $error("answer without read");
    chk_fault_reserved:
        assert property (rd_at(7'h45) |=> !read_rsp.data[7] && !read_rsp.data[0]) else $error("fault reserved");
    chk_wake_a_reserved:
        assert property (rd_at(7'h46) |=> read_rsp.data[6:1] ==? 6'b0x_x000) else $error("wake a reserved");
    chk_wake_b_upper:
        assert property (rd_at(7'h47) |=> read_rsp.data[7:4] == 4'h0) else $error("wake b reserved");
    chk_level_fixed:
        assert property (rd_at(7'h48) |=> read_rsp.data[6] && read_rsp.data[4:1] == 4'h0) else $error("level fixed");
    chk_mode_latch:
        assert property (flag_seen(wake_event.regulator_mode_change, 7'h46, 7)) else $error("mode flag lost");
    chk_can_latch:
        assert property (flag_seen(wake_event.can_bus_wake, 7'h46, 5)) else $error("can wake lost");
    chk_lin_wake_latch:
        assert property (flag_seen(wake_event.lin_wake[3], 7'h47, 3)) else $error("lin wake lost");
    chk_thermal_flag:
        assert property (1'b1 |=> thermal_shutdown_first == $past(any_thermal)) else $error("thermal flag");
    chk_tx_drop:
        assert property (lin_event[0].thermal_shutdown |=> !tx_enable[0]) else $error("tx not dropped");
    chk_tx_holdoff:
        assert property ($rose(tx_enable[0]) |-> ok_cnt >= TX_ENABLE_CYCLES) else $error("tx enabled early");
    chk_tx_recover:
        assert property (ok_cnt >= TX_ENABLE_CYCLES + 8 |-> tx_enable[0]) else $error("tx not recovered");
endmodule

// ### tb/status_host_model.sv
// host model: issues single-byte status reads on the read port
// assumes: shares ref_clk with the bank, answer within four cycles
`timescale 1ns/1ps
module status_host_model (
    // clock
    input  wire logic                           ref_clk,
    // read port
    input  lin_fail_wake_status_pkg::read_rsp_s read_rsp,
    output lin_fail_wake_status_pkg::read_req_s read_req
);
    import lin_fail_wake_status_pkg::*;
    initial read_req = '{valid: 1'b0, addr: 7'h7F};
    // address inverted when idle so a stale value never passes for a request
    task automatic read_byte(input logic [6:0] a, output logic [7:0] d, output logic ok);
        ok = 1'b0;
        d = 8'h00;
        @(posedge ref_clk);
        #2;
        read_req = '{valid: 1'b1, addr: a};
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge ref_clk);
            #2;
            read_req = '{valid: 1'b0, addr: ~a};
            if (read_rsp.ack === 1'b1) begin
                ok = 1'b1;
                d = read_rsp.data;
            end
        end
    endtask
endmodule

// ### tb/tb.sv
// testbench for the lin failure / wake status bank
// assumes: host model and checker from tb/, reset held 8 cycles
`timescale 1ns/1ps
module tb;
    import lin_fail_wake_status_pkg::*;
    localparam int unsigned TXN = 4;
    logic             ref_clk = 1'b0;
    logic             reset = 1'b1;
    logic             soft_reset = 1'b0;
    logic             restart = 1'b0;
    logic             clk_en = 1'b1;
    logic [2:0]       txd = 3'b111;
    logic             test_pin = 1'b0;
    logic             wake_pin = 1'b0;
    logic             cfg_bit = 1'b0;
    lin_event_s [2:0] ev = {3{6'b000101}};
    wake_event_s      wk = '0;
    read_req_s        req;
    read_rsp_s        rsp;
    logic [2:0]       tx_en;
    logic             therm1;
    logic [7:0]       got;
    logic             ok;
    int               err_total = 0;
    int               comparisons = 0;
    int               cycles = 0;
    int               seed = 32'h0c521cdf;
    int               m[3] = '{0, 0, 0};
    lin_fail_wake_status_regs #(.TX_ENABLE_CYCLES(TXN)) dut (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en), .soft_reset(soft_reset), .restart(restart),
        .lin_transmit_input(txd), .test_pin(test_pin), .wake_input_pin(wake_pin),
        .fail_output_config_bit(cfg_bit), .lin_event(ev), .wake_event(wk), .read_req(req),
        .read_rsp(rsp), .tx_enable(tx_en), .thermal_shutdown_first(therm1));
    status_host_model host (.ref_clk(ref_clk), .read_rsp(rsp), .read_req(req));
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            conclude();
        end
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk_byte(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_flag(input string n, input logic e, input logic g);
        chk_byte(n, {7'h0, e}, {7'h0, g});
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #2;
    endtask
    // compare against the model; a read empties the model's copy
    task automatic rd(input logic [6:0] a);
        logic [7:0] e;
        e = (a >= 7'h45 && a <= 7'h47) ? 8'(m[a - 7'h45]) : 8'h00;
        if (a == 7'h48) e = {test_pin, 1'b1, cfg_bit, 4'h0, wake_pin};
        host.read_byte(a, got, ok);
        chk_flag("read ack", 1'b1, ok);
        chk_byte($sformatf("reg %h", a), e, got);
        if (a >= 7'h45 && a <= 7'h47) m[a - 7'h45] = 0;
    endtask
    task automatic wake_pulse(input logic [7:0] w);
        wk = w;
        tick(1);
        wk = '0;
        m[1] |= {w[7], 1'b0, w[6], w[5], 3'b000, w[4]};
        m[2] |= w[3:0];
    endtask
    // k: 0 thermal, 1 transmit timeout, 2 bus timeout; lane held dominant meanwhile
    task automatic fault(input int ln, input int k);
        ev[ln][5 - k] = 1'b1;
        txd[ln] = 1'b0;
        tick(1);
        if (k != 0) ev[ln][5 - k] = 1'b0;
        tick(2);
        chk_flag("tx enable off", 1'b0, tx_en[ln]);
        if (k == 0) chk_flag("thermal first", 1'b1, therm1);
        ev[ln][5] = 1'b0;
        m[0] |= (k == 0 ? 1 : k + 1) << (1 + 2 * ln);
        tick(3);
        txd[ln] = 1'b1;
        tick(TXN);
        chk_flag("tx enable held", 1'b0, tx_en[ln]);
        tick(8);
        chk_flag("tx enable back", 1'b1, tx_en[ln]);
    endtask
    initial begin
        {test_pin, wake_pin} = 2'($random(seed));
        tick(8);
        reset = 1'b0;
        for (int a = 'h44; a <= 'h49; a++) rd(7'(a));
        for (int i = 0; i < 6; i++) begin
            wake_pulse(8'($random(seed)));
            wake_pulse(8'($random(seed)));
            rd(7'h46);
            rd(7'h47);
        end
        for (int i = 0; i < 4; i++) begin
            {test_pin, wake_pin, cfg_bit} = 3'($random(seed));
            tick(6);
            rd(7'h48);
        end
        // a frozen bank must not latch a wake burst
        tick(1);
        clk_en = 1'b0;
        wk = 8'hFF;
        tick(1);
        wk = '0;
        tick(1);
        clk_en = 1'b1;
        rd(7'h46);
        rd(7'h47);
        for (int ln = 0; ln < 3; ln++) begin
            for (int k = 0; k < 3; k++) begin
                fault(ln, k);
                rd(7'h45);
                rd(7'h45);
            end
        end
        // supply dip on lane 1 holds the transmitter off until it recovers
        ev[1][0] = 1'b0;
        tick(3);
        chk_flag("tx enable off", 1'b0, tx_en[1]);
        ev[1][0] = 1'b1;
        tick(1);
        chk_flag("tx enable held", 1'b0, tx_en[1]);
        tick(8);
        chk_flag("tx enable back", 1'b1, tx_en[1]);
        wake_pulse(8'hFF);
        restart = 1'b1;
        tick(1);
        restart = 1'b0;
        rd(7'h46);
        rd(7'h47);
        wake_pulse(8'hFF);
        // wake capable ends a transmit timeout although txd stays low
        txd[2] = 1'b0;
        ev[2][4] = 1'b1;
        tick(1);
        ev[2][4] = 1'b0;
        ev[2][1] = 1'b1;
        tick(1);
        ev[2][1] = 1'b0;
        m[0] = 32'h40;
        rd(7'h45);
        rd(7'h45);
        txd[2] = 1'b1;
        tick(3);
        ev[2][4] = 1'b1;
        tick(1);
        ev[2][4] = 1'b0;
        tick(3);
        soft_reset = 1'b1;
        tick(1);
        soft_reset = 1'b0;
        m = '{0, 0, 0};
        for (int a = 'h45; a <= 'h47; a++) rd(7'(a));
        conclude();
    end
endmodule
bind lin_fail_wake_status_regs status_bank_checker #(.TX_ENABLE_CYCLES(TX_ENABLE_CYCLES)) checker_i (
    .ref_clk, .reset, .soft_reset, .lin_transmit_input, .lin_event, .wake_event,
    .read_req, .read_rsp, .tx_enable, .thermal_shutdown_first);
